/* File: shared/tbf_pkg.sv */
// Purpose: Shared constants, types and decoders for the baseline tracking filter
// Assumes: 10-bit second-stage readings, 8-bit limit codes, 6-bit half delta codes
// Notes:   All widths fixed

package tbf_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DATA_W  = 10;
	localparam int CODE_W  = 8;
	localparam int HALF_W  = 6;
	localparam int LIMIT_W = 9;
	localparam int SUM_W   = 18;

	// ------------------------------------------------------------
	// Reset values and code points
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0]  BASELINE_RESET = 10'h000;
	localparam logic [DATA_W-1:0]  DATA_MAX       = 10'h3FF;
	localparam logic [LIMIT_W-1:0] COUNT_RESET    = 9'h000;
	localparam logic [SUM_W-1:0]   SUM_RESET      = 18'h00000;
	localparam logic [CODE_W-1:0]  CODE_TOP       = 8'hFF;
	localparam logic [LIMIT_W-1:0] LIMIT_TOP      = 9'h0FF;
	localparam logic [LIMIT_W-1:0] LIMIT_STEP     = 9'h001;
	localparam logic [HALF_W-1:0]  HALF_FORBIDDEN = 6'h00;
	localparam logic [HALF_W-1:0]  HALF_MIN       = 6'h01;

	// ------------------------------------------------------------
	// Filter conditions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {COND_RISE, COND_FALL, COND_TOUCH} tbf_cond_e;

	// ------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------
	// Code n gives n+1, top code gives 255
	function automatic logic [LIMIT_W-1:0] tbf_decode_limit(input logic [CODE_W-1:0] code);
		if (code == CODE_TOP)
			return LIMIT_TOP;
		else
			return {1'b0, code} + LIMIT_STEP;
	endfunction

	// Forbidden code 0 is read as 1
	function automatic logic [HALF_W-1:0] tbf_decode_half(input logic [HALF_W-1:0] code);
		if (code == HALF_FORBIDDEN)
			return HALF_MIN;
		else
			return code;
	endfunction

endpackage

/* File: core/tbf_param_sel.sv */
// Purpose: Selects and decodes the parameter set of the active filter condition
// Assumes: Condition held by the caller
// Notes:   Touched set has no max half delta

`timescale 1ns/1ps

module tbf_param_sel
	import tbf_pkg::*;
(
	input  wire logic                         ref_clk,
	input  wire logic                         reset_n,
	input  wire tbf_pkg::tbf_cond_e           cond,
	input  wire logic [tbf_pkg::HALF_W-1:0]   rise_max_half_delta,
	input  wire logic [tbf_pkg::HALF_W-1:0]   rise_noise_half_delta,
	input  wire logic [tbf_pkg::CODE_W-1:0]   rise_consecutive_sample_limit,
	input  wire logic [tbf_pkg::CODE_W-1:0]   rise_averaging_delay_limit,
	input  wire logic [tbf_pkg::HALF_W-1:0]   fall_max_half_delta,
	input  wire logic [tbf_pkg::HALF_W-1:0]   fall_noise_half_delta,
	input  wire logic [tbf_pkg::CODE_W-1:0]   fall_consecutive_sample_limit,
	input  wire logic [tbf_pkg::CODE_W-1:0]   fall_averaging_delay_limit,
	input  wire logic [tbf_pkg::HALF_W-1:0]   touch_noise_half_delta,
	input  wire logic [tbf_pkg::CODE_W-1:0]   touch_consecutive_sample_limit,
	input  wire logic [tbf_pkg::CODE_W-1:0]   touch_averaging_delay_limit,
	output logic      [tbf_pkg::HALF_W-1:0]   max_half_delta,
	output logic      [tbf_pkg::HALF_W-1:0]   noise_half_delta,
	output logic      [tbf_pkg::LIMIT_W-1:0]  sample_limit,
	output logic      [tbf_pkg::LIMIT_W-1:0]  delay_limit
);
	import tbf_pkg::*;

	// ------------------------------------------------------------
	// Set selection
	// ------------------------------------------------------------
	always_comb
	begin
		case (cond)
			COND_FALL:
			begin
				max_half_delta   = tbf_decode_half(fall_max_half_delta);
				noise_half_delta = tbf_decode_half(fall_noise_half_delta);
				sample_limit     = tbf_decode_limit(fall_consecutive_sample_limit);
				delay_limit      = tbf_decode_limit(fall_averaging_delay_limit);
			end
			COND_TOUCH:
			begin
				max_half_delta   = HALF_MIN;
				noise_half_delta = tbf_decode_half(touch_noise_half_delta);
				sample_limit     = tbf_decode_limit(touch_consecutive_sample_limit);
				delay_limit      = tbf_decode_limit(touch_averaging_delay_limit);
			end
			default:
			begin
				max_half_delta   = tbf_decode_half(rise_max_half_delta);
				noise_half_delta = tbf_decode_half(rise_noise_half_delta);
				sample_limit     = tbf_decode_limit(rise_consecutive_sample_limit);
				delay_limit      = tbf_decode_limit(rise_averaging_delay_limit);
			end
		endcase
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sample_code_zero_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(cond == COND_FALL && fall_consecutive_sample_limit == 8'h00) |-> sample_limit == 9'h001)
		else $error("Sample limit code 0 not one sample");

	delay_code_top_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(cond == COND_RISE && rise_averaging_delay_limit == 8'hFF) |-> delay_limit == 9'h0FF)
		else $error("Delay limit top code not 255");

	fall_set_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(cond == COND_FALL && fall_max_half_delta != 6'h00) |-> max_half_delta == fall_max_half_delta)
		else $error("Falling set not selected");

endmodule

/* File: core/tbf_averager.sv */
// Purpose: Averages a programmable number of readings ahead of the baseline filter
// Assumes: Readings arrive at least two cycles apart
// Notes:   Clear discards the partial sum and the reading of the same cycle

`timescale 1ns/1ps

module tbf_averager
	import tbf_pkg::*;
(
	input  wire logic                         ref_clk,
	input  wire logic                         reset_n,
	input  wire logic                         sample_valid,
	input  wire logic                         clear,
	input  wire logic [tbf_pkg::DATA_W-1:0]   sample_data,
	input  wire logic [tbf_pkg::LIMIT_W-1:0]  delay_limit,
	output logic                              avg_valid,
	output logic      [tbf_pkg::DATA_W-1:0]   avg_data
);
	import tbf_pkg::*;

	logic [SUM_W-1:0]   sum;
	logic [LIMIT_W-1:0] cnt;
	logic [SUM_W-1:0]   next_sum;
	logic [LIMIT_W-1:0] next_cnt;
	logic               next_avg_valid;
	logic [DATA_W-1:0]  next_avg_data;
	logic [SUM_W-1:0]   total;
	logic [SUM_W-1:0]   quotient;

	// ------------------------------------------------------------
	// Accumulate and divide
	// ------------------------------------------------------------
	always_comb
	begin
		total          = sum + SUM_W'(sample_data);
		quotient       = total / SUM_W'(delay_limit);
		next_sum       = sum;
		next_cnt       = cnt;
		next_avg_valid = 1'b0;
		next_avg_data  = avg_data;
		if (clear)
		begin
			next_sum = SUM_RESET;
			next_cnt = COUNT_RESET;
		end
		else if (sample_valid)
		begin
			if (cnt + LIMIT_STEP >= delay_limit)
			begin
				next_avg_data  = quotient[DATA_W-1:0];
				next_avg_valid = 1'b1;
				next_sum       = SUM_RESET;
				next_cnt       = COUNT_RESET;
			end
			else
			begin
				next_sum = total;
				next_cnt = cnt + LIMIT_STEP;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			sum       <= SUM_RESET;
			cnt       <= COUNT_RESET;
			avg_valid <= 1'b0;
			avg_data  <= BASELINE_RESET;
		end
		else
		begin
			sum       <= next_sum;
			cnt       <= next_cnt;
			avg_valid <= next_avg_valid;
			avg_data  <= next_avg_data;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	avg_release_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sample_valid && !clear && cnt + 9'h001 >= delay_limit) |=> avg_valid)
		else $error("Average not released at delay limit");

	avg_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		!(sample_valid && !clear && cnt + 9'h001 >= delay_limit) |=> !avg_valid)
		else $error("Average released early");

endmodule

/* File: core/tbf_baseline_filter.sv */
// Purpose: Baseline tracking filter for one electrode
// Assumes: sample_valid pulses once per electrode sample, readings synchronous
// Notes:   First reading after reset seeds the baseline
//
// What this block does
// - Non-noise only after enough consecutive large samples
// - Sample limit code n means n+1, top 255
// - Delay limit code n means n+1, top 255
// - Condition change clears all counters, abandons step
// - Reading below baseline selects falling set
// - Small deviation copies averaged reading into baseline
// - Counted large deviations step baseline by noise half delta
// - Alternating large deviations leave baseline unchanged outside touched state
// - Average delay-limit readings before baseline filter
// - Separate parameter sets for rising and falling
// - Touched state uses only noise, count, delay
// - Touch switches to slow touched-state filter
// - Half delta codes 1-63, never zero

`timescale 1ns/1ps

module tbf_baseline_filter
	import tbf_pkg::*;
(
	input  wire logic                         ref_clk,
	input  wire logic                         reset_n,
	input  wire logic                         sample_valid,
	input  wire logic [tbf_pkg::DATA_W-1:0]   filtered_data,
	input  wire logic                         touch_active,
	input  wire logic [tbf_pkg::HALF_W-1:0]   rise_max_half_delta,
	input  wire logic [tbf_pkg::HALF_W-1:0]   rise_noise_half_delta,
	input  wire logic [tbf_pkg::CODE_W-1:0]   rise_consecutive_sample_limit,
	input  wire logic [tbf_pkg::CODE_W-1:0]   rise_averaging_delay_limit,
	input  wire logic [tbf_pkg::HALF_W-1:0]   fall_max_half_delta,
	input  wire logic [tbf_pkg::HALF_W-1:0]   fall_noise_half_delta,
	input  wire logic [tbf_pkg::CODE_W-1:0]   fall_consecutive_sample_limit,
	input  wire logic [tbf_pkg::CODE_W-1:0]   fall_averaging_delay_limit,
	input  wire logic [tbf_pkg::HALF_W-1:0]   touch_noise_half_delta,
	input  wire logic [tbf_pkg::CODE_W-1:0]   touch_consecutive_sample_limit,
	input  wire logic [tbf_pkg::CODE_W-1:0]   touch_averaging_delay_limit,
	output logic      [tbf_pkg::DATA_W-1:0]   baseline,
	output logic                              baseline_update,
	output tbf_pkg::tbf_cond_e                filter_cond,
	output logic      [tbf_pkg::LIMIT_W-1:0]  noise_count
);
	import tbf_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic               primed;
	logic               next_primed;
	tbf_cond_e          next_filter_cond;
	logic [DATA_W-1:0]  next_baseline;
	logic               next_baseline_update;
	logic [LIMIT_W-1:0] next_noise_count;

	tbf_cond_e          sample_cond;
	logic               cond_change;
	logic               avg_clear;
	logic               apply;
	logic               avg_valid;
	logic [DATA_W-1:0]  avg_data;
	logic               avg_above;
	logic [DATA_W-1:0]  deviation;
	logic               small_dev;
	logic [LIMIT_W-1:0] count_inc;
	logic               count_reached;
	logic [DATA_W:0]    step_up;
	logic [DATA_W-1:0]  step_target;

	logic [HALF_W-1:0]  max_half_delta;
	logic [HALF_W-1:0]  noise_half_delta;
	logic [LIMIT_W-1:0] sample_limit;
	logic [LIMIT_W-1:0] delay_limit;

	// ------------------------------------------------------------
	// Parameter selection and averaging
	// ------------------------------------------------------------
	tbf_param_sel u_param_sel
	(
		.ref_clk                        (ref_clk),
		.reset_n                        (reset_n),
		.cond                           (filter_cond),
		.rise_max_half_delta            (rise_max_half_delta),
		.rise_noise_half_delta          (rise_noise_half_delta),
		.rise_consecutive_sample_limit  (rise_consecutive_sample_limit),
		.rise_averaging_delay_limit     (rise_averaging_delay_limit),
		.fall_max_half_delta            (fall_max_half_delta),
		.fall_noise_half_delta          (fall_noise_half_delta),
		.fall_consecutive_sample_limit  (fall_consecutive_sample_limit),
		.fall_averaging_delay_limit     (fall_averaging_delay_limit),
		.touch_noise_half_delta         (touch_noise_half_delta),
		.touch_consecutive_sample_limit (touch_consecutive_sample_limit),
		.touch_averaging_delay_limit    (touch_averaging_delay_limit),
		.max_half_delta                 (max_half_delta),
		.noise_half_delta               (noise_half_delta),
		.sample_limit                   (sample_limit),
		.delay_limit                    (delay_limit)
	);

	tbf_averager u_averager
	(
		.ref_clk      (ref_clk),
		.reset_n      (reset_n),
		.sample_valid (sample_valid),
		.clear        (avg_clear),
		.sample_data  (filtered_data),
		.delay_limit  (delay_limit),
		.avg_valid    (avg_valid),
		.avg_data     (avg_data)
	);

	// ------------------------------------------------------------
	// Condition tracking
	// ------------------------------------------------------------
	always_comb
	begin
		if (touch_active)
			sample_cond = COND_TOUCH;
		else if (filtered_data < baseline)
			sample_cond = COND_FALL;
		else if (filtered_data > baseline)
			sample_cond = COND_RISE;
		else
			sample_cond = filter_cond;
	end

	assign cond_change = sample_valid && primed && (sample_cond != filter_cond);
	assign avg_clear   = cond_change || (sample_valid && !primed);
	assign apply       = avg_valid && !avg_clear;

	// ------------------------------------------------------------
	// Deviation and step
	// ------------------------------------------------------------
	always_comb
	begin
		avg_above     = avg_data > baseline;
		deviation     = avg_above ? avg_data - baseline : baseline - avg_data;
		small_dev     = (filter_cond != COND_TOUCH) &&
			(deviation < DATA_W'({max_half_delta, 1'b0}));
		count_inc     = noise_count + LIMIT_STEP;
		count_reached = count_inc >= sample_limit;
		step_up       = {1'b0, baseline} + (DATA_W + 1)'(noise_half_delta);
		if (avg_above)
			step_target = step_up[DATA_W] ? DATA_MAX : step_up[DATA_W-1:0];
		else if (baseline > DATA_W'(noise_half_delta))
			step_target = baseline - DATA_W'(noise_half_delta);
		else
			step_target = BASELINE_RESET;
	end

	// ------------------------------------------------------------
	// Baseline state
	// ------------------------------------------------------------
	always_comb
	begin
		next_primed          = primed;
		next_filter_cond     = filter_cond;
		next_baseline        = baseline;
		next_baseline_update = 1'b0;
		next_noise_count     = noise_count;
		if (sample_valid && !primed)
		begin
			next_primed      = 1'b1;
			next_baseline    = filtered_data;
			next_filter_cond = touch_active ? COND_TOUCH : COND_RISE;
			next_noise_count = COUNT_RESET;
		end
		else if (cond_change)
		begin
			next_filter_cond = sample_cond;
			next_noise_count = COUNT_RESET;
		end
		else if (apply)
		begin
			if (small_dev)
			begin
				next_baseline        = avg_data;
				next_baseline_update = 1'b1;
				next_noise_count     = COUNT_RESET;
			end
			else if (deviation == BASELINE_RESET)
				next_noise_count = COUNT_RESET;
			else if (count_reached)
			begin
				next_baseline        = step_target;
				next_baseline_update = 1'b1;
				next_noise_count     = COUNT_RESET;
			end
			else
				next_noise_count = count_inc;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			primed          <= 1'b0;
			filter_cond     <= COND_RISE;
			baseline        <= BASELINE_RESET;
			baseline_update <= 1'b0;
			noise_count     <= COUNT_RESET;
		end
		else
		begin
			primed          <= next_primed;
			filter_cond     <= next_filter_cond;
			baseline        <= next_baseline;
			baseline_update <= next_baseline_update;
			noise_count     <= next_noise_count;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_change;
		sample_valid && primed && (sample_cond != filter_cond);
	endsequence

	sequence s_large_apply;
		apply && !small_dev && (deviation != 10'h000);
	endsequence

	sequence s_seed;
		sample_valid && !primed;
	endsequence

	cond_clear_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_change |=> (noise_count == 9'h000) && !avg_valid)
		else $error("Counters not cleared on condition change");

	osc_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_change |=> $stable(baseline) ##1 $stable(baseline))
		else $error("Baseline moved on condition change");

	fall_select_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sample_valid && primed && !touch_active && filtered_data < baseline) |=> filter_cond == COND_FALL)
		else $error("Falling set not chosen");

	rise_select_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sample_valid && primed && !touch_active && filtered_data > baseline) |=> filter_cond == COND_RISE)
		else $error("Rising set not chosen");

	touch_select_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(sample_valid && primed && touch_active) |=> filter_cond == COND_TOUCH)
		else $error("Touched filter not chosen");

	small_track_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(apply && small_dev) |=> (baseline == $past(avg_data)) && baseline_update)
		else $error("Small deviation not tracked");

	noise_count_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_large_apply and (apply && !count_reached)) |=>
			$stable(baseline) && (noise_count == $past(noise_count) + 9'h001))
		else $error("Large deviation not counted");

	noise_step_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_large_apply and (apply && count_reached && avg_above && !step_up[10])) |=>
			(baseline - $past(baseline)) == 10'($past(noise_half_delta)) && noise_count == 9'h000)
		else $error("Noise step not applied");

	touch_only_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(apply && filter_cond == COND_TOUCH && !count_reached) |=> $stable(baseline))
		else $error("Touched baseline moved before count");

	seed_load_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_seed |=> (baseline == $past(filtered_data)) && !baseline_update &&
			(filter_cond == ($past(touch_active) ? COND_TOUCH : COND_RISE)))
		else $error("First reading not seeded");

	update_pulse_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		baseline_update |=> !baseline_update)
		else $error("Baseline update longer than one cycle");

	change_abandon_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_change |=> !baseline_update)
		else $error("Filter step finished across condition change");

	count_bound_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		noise_count < sample_limit)
		else $error("Noise count reached sample limit");

	touch_no_track_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(filter_cond == COND_TOUCH) |-> !small_dev)
		else $error("Touched filter used small deviation path");

	small_clear_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(apply && small_dev) |=> noise_count == 9'h000)
		else $error("Noise count kept after small deviation");

	large_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_large_apply and (apply && !count_reached)) |=> !baseline_update)
		else $error("Baseline stepped before count reached");

	noise_down_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_large_apply and (apply && count_reached && !avg_above && baseline > 10'(noise_half_delta))) |=>
			($past(baseline) - baseline) == 10'($past(noise_half_delta)) && noise_count == 9'h000)
		else $error("Noise step down not applied");

endmodule

/* File: testbench/tbf_stage_model.sv */
// Purpose: Second-stage filter and touch detection stand-in feeding the baseline filter
// Assumes: Driven from the falling edge of ref_clk
// Notes:   Reading line shows inverted data between samples

`timescale 1ns/1ps

module tbf_stage_model
	import tbf_pkg::*;
(
	input  wire logic                        ref_clk,
	output logic                             sample_valid,
	output logic      [tbf_pkg::DATA_W-1:0]  filtered_data,
	output logic                             touch_active
);
	import tbf_pkg::*;

	initial
	begin
		sample_valid  = 1'b0;
		filtered_data = 10'h155;
		touch_active  = 1'b0;
	end

	// ------------------------------------------------------------
	// One reading, then the spacing the filter needs
	// ------------------------------------------------------------
	task automatic send(input logic [DATA_W-1:0] data, input logic touch);
		@(negedge ref_clk);
		sample_valid  = 1'b1;
		filtered_data = data;
		touch_active  = touch;
		@(negedge ref_clk);
		sample_valid  = 1'b0;
		filtered_data = ~data;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

/* File: testbench/test_tbf_baseline_filter.sv */
// Purpose: Self-checking bench for the baseline tracking filter
// Assumes: Configuration levels changed only between scenarios, readings from the stage model
// Notes:   Expected baselines worked out by hand per scenario

`timescale 1ns/1ps

module test_tbf_baseline_filter;
	import tbf_pkg::*;

	logic                 ref_clk;
	logic                 reset_n;
	logic                 sample_valid;
	logic [DATA_W-1:0]    filtered_data;
	logic                 touch_active;
	logic [DATA_W-1:0]    baseline;
	logic                 baseline_update;
	tbf_cond_e            filter_cond;
	logic [LIMIT_W-1:0]   noise_count;
	int                   n_fail;
	int                   n_checks;
	int                   n_upd;
	logic [HALF_W-1:0]    rise_max_half_delta = 6'h01;
	logic [CODE_W-1:0]    rise_averaging_delay_limit = 8'h00;
	logic [HALF_W-1:0]    fall_max_half_delta = 6'h02;
	logic [HALF_W-1:0]    fall_noise_half_delta = 6'h05;
	logic [HALF_W-1:0]    touch_noise_half_delta = 6'h01;
	logic [CODE_W-1:0]    touch_consecutive_sample_limit = 8'h00;

	// ------------------------------------------------------------
	// Clock, partner and design
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	tbf_stage_model i_src (
		.ref_clk       (ref_clk),
		.sample_valid  (sample_valid),
		.filtered_data (filtered_data),
		.touch_active  (touch_active)
	);

	tbf_baseline_filter i_dut (
		.ref_clk                        (ref_clk),
		.reset_n                        (reset_n),
		.sample_valid                   (sample_valid),
		.filtered_data                  (filtered_data),
		.touch_active                   (touch_active),
		.rise_max_half_delta            (rise_max_half_delta),
		.rise_noise_half_delta          (6'h03),
		.rise_consecutive_sample_limit  (8'h01),
		.rise_averaging_delay_limit     (rise_averaging_delay_limit),
		.fall_max_half_delta            (fall_max_half_delta),
		.fall_noise_half_delta          (fall_noise_half_delta),
		.fall_consecutive_sample_limit  (8'h00),
		.fall_averaging_delay_limit     (8'h01),
		.touch_noise_half_delta         (touch_noise_half_delta),
		.touch_consecutive_sample_limit (touch_consecutive_sample_limit),
		.touch_averaging_delay_limit    (8'h00),
		.baseline                       (baseline),
		.baseline_update                (baseline_update),
		.filter_cond                    (filter_cond),
		.noise_count                    (noise_count)
	);

	always @(posedge ref_clk)
		if (baseline_update === 1'b1)
			n_upd++;

	// ------------------------------------------------------------
	// Compare and report
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic state(input logic [DATA_W-1:0] b, input logic [1:0] c, input logic [LIMIT_W-1:0] n);
		check({6'h00, baseline}, {6'h00, b});
		check({14'h0000, filter_cond}, {14'h0000, c});
		check({7'h00, noise_count}, {7'h00, n});
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_seed_small();
		state(10'h000, COND_RISE, 9'h000);
		i_src.send(10'd700, 1'b0);
		state(10'd700, COND_RISE, 9'h000);
		check(16'(n_upd), 16'd0);
		i_src.send(10'd701, 1'b0);
		state(10'd701, COND_RISE, 9'h000);
		check(16'(n_upd), 16'd1);
		$display("Test seed and small step done");
	endtask

	task automatic t_noise_count();
		i_src.send(10'd720, 1'b0);
		state(10'd701, COND_RISE, 9'h001);
		i_src.send(10'd720, 1'b0);
		state(10'd704, COND_RISE, 9'h000);
		check(16'(n_upd), 16'd2);
		$display("Test counted noise step done");
	endtask

	task automatic t_oscillate();
		int i;
		for (i = 0; i < 4; i++)
		begin
			i_src.send(i[0] ? 10'd730 : 10'd680, 1'b0);
			state(10'd704, i[0] ? COND_RISE : COND_FALL, 9'h000);
		end
		check(16'(n_upd), 16'd2);
		$display("Test oscillating data done");
	endtask

	task automatic t_falling();
		i_src.send(10'd680, 1'b0);
		state(10'd704, COND_FALL, 9'h000);
		i_src.send(10'd680, 1'b0);
		state(10'd704, COND_FALL, 9'h000);
		i_src.send(10'd680, 1'b0);
		state(10'd699, COND_FALL, 9'h000);
		$display("Test falling set done");
	endtask

	task automatic t_average();
		i_src.send(10'd698, 1'b0);
		check({6'h00, baseline}, {6'h00, 10'd699});
		i_src.send(10'd696, 1'b0);
		check({6'h00, baseline}, {6'h00, 10'd697});
		$display("Test averaging done");
	endtask

	task automatic t_touch();
		i_src.send(10'd697, 1'b1);
		state(10'd697, COND_TOUCH, 9'h000);
		i_src.send(10'd650, 1'b1);
		state(10'd696, COND_TOUCH, 9'h000);
		i_src.send(10'd650, 1'b1);
		state(10'd695, COND_TOUCH, 9'h000);
		i_src.send(10'd700, 1'b0);
		state(10'd695, COND_RISE, 9'h000);
		$display("Test touched filter done");
	endtask

	task automatic t_slow_average();
		int i;
		rise_averaging_delay_limit = 8'hFF;
		for (i = 0; i < 254; i++)
			i_src.send(10'd696, 1'b0);
		state(10'd695, COND_RISE, 9'h000);
		i_src.send(10'd696, 1'b0);
		state(10'd696, COND_RISE, 9'h000);
		check(16'(n_upd), 16'd7);
		rise_averaging_delay_limit = 8'h00;
		$display("Test top delay code done");
	endtask

	task automatic t_reset_touch();
		reset_n = 1'b0;
		touch_consecutive_sample_limit = 8'h01;
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		state(10'h000, COND_RISE, 9'h000);
		i_src.send(10'd600, 1'b1);
		state(10'd600, COND_TOUCH, 9'h000);
		i_src.send(10'd580, 1'b1);
		state(10'd600, COND_TOUCH, 9'h001);
		i_src.send(10'd580, 1'b1);
		state(10'd599, COND_TOUCH, 9'h000);
		check(16'(n_upd), 16'd8);
		$display("Test reset and touched count done");
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		n_fail   = 0;
		n_checks = 0;
		n_upd    = 0;
		reset_n  = 1'b0;
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		t_seed_small();
		t_noise_count();
		t_oscillate();
		t_falling();
		t_average();
		t_touch();
		t_slow_average();
		t_reset_touch();
		print_verdict();
	end

	initial
	begin
		#1000000;
		n_fail++;
		print_verdict();
	end
endmodule
